// ==== rtl/cpx_unpacker.sv ====
// Parallel camera pixel unpacker, one lane per camera port
module cpx_unpacker import cpx_pkg::*; #(
	parameter int NUM_PORTS = CPX_NUM_PORTS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [NUM_PORTS-1:0] pix_clk,
	input wire logic [NUM_PORTS-1:0][DATA_W-1:0] sensor_data_pin,
	input wire logic [NUM_PORTS-1:0] sensor_valid,
	input wire logic [NUM_PORTS-1:0] sensor_line_start,
	input wire logic [NUM_PORTS-1:0][FMT_W-1:0] fmt_sel,
	output logic [NUM_PORTS-1:0] pix_valid,
	input wire logic [NUM_PORTS-1:0] pix_ready,
	output logic [NUM_PORTS-1:0][FMT_W-1:0] pix_fmt,
	output logic [NUM_PORTS-1:0][COMP_W-1:0] pix_c0,
	output logic [NUM_PORTS-1:0][COMP_W-1:0] pix_c1,
	output logic [NUM_PORTS-1:0][COMP_W-1:0] pix_c2,
	output logic [NUM_PORTS-1:0] overrun
);
	// ==========================================================
	// Decoding helpers

	// Index of the final bus cycle of one pixel
	function automatic logic [CNT_W-1:0] cpx_last(input logic [FMT_W-1:0] f);
		logic [CNT_W-1:0] l;
		l = LAST_1C;
		case (f)
			FMT_RGB565_2C, FMT_YCC8_2C: begin
				l = LAST_2C; // Two cycles per pixel
			end
			FMT_RGB565_3C, FMT_RGB666_3C, FMT_RGB888_3C: begin
				l = LAST_3C; // Three cycles per pixel
			end
			default: begin
				l = LAST_1C; // Single cycle, or unknown code
			end
		endcase
		return l;
	endfunction : cpx_last

	// Fold one bus cycle into the pixel being built.
	// Slots: c0 red or luma, c1 green or chroma, c2 blue.
	// Only the pins a format uses are sliced; the rest never reach a slot.
	function automatic logic [PIXC_W-1:0] cpx_merge(
		input logic [FMT_W-1:0] f,
		input logic [CNT_W-1:0] c,
		input logic [DATA_W-1:0] d,
		input logic [PIXC_W-1:0] acc
	);
		logic [COMP_W-1:0] r;
		logic [COMP_W-1:0] g;
		logic [COMP_W-1:0] b;
		r = acc[3*COMP_W-1:2*COMP_W];
		g = acc[2*COMP_W-1:COMP_W];
		b = acc[COMP_W-1:0];
		case (f)
			FMT_RGB565_2C: begin
				if (c == CNT_RESET) begin
					g = {7'h0, d[19:17]}; // Green low bits first
					b = {5'h0, d[16:12]}; // Blue in same cycle
				end else begin
					r = {5'h0, d[19:15]}; // Red second
					g[5:3] = d[14:12]; // Green high bits
				end
			end
			FMT_RGB565_3C: begin
				// Repeated bits on 14..12 are dropped; green keeps pin 14 and drops 13..12
				if (c == CNT_RESET) begin
					r = {5'h0, d[19:15]};
				end else if (c == LAST_2C) begin
					g = {4'h0, d[19:14]};
				end else begin
					b = {5'h0, d[19:15]};
				end
			end
			FMT_RGB666_3C: begin
				// Pins 13..12 only repeat bits 5..4
				if (c == CNT_RESET) begin
					r = {4'h0, d[19:14]};
				end else if (c == LAST_2C) begin
					g = {4'h0, d[19:14]};
				end else begin
					b = {4'h0, d[19:14]};
				end
			end
			FMT_RGB888_3C: begin
				if (c == CNT_RESET) begin
					r = {2'h0, d[19:12]};
				end else if (c == LAST_2C) begin
					g = {2'h0, d[19:12]};
				end else begin
					b = {2'h0, d[19:12]};
				end
			end
			FMT_YCC8_2C: begin
				if (c == CNT_RESET) begin
					g = {2'h0, d[19:12]}; // Chroma sample first
					b = '0; // No third slot for luma/chroma
				end else begin
					r = {2'h0, d[19:12]}; // Luma sample second
				end
			end
			FMT_RGB565_16: begin
				r = {5'h0, d[19:15]};
				g = {4'h0, d[14:9]};
				b = {5'h0, d[8:4]};
			end
			FMT_YCC16_A: begin
				r = {2'h0, d[19:12]};
				g = {2'h0, d[11:4]};
				b = '0;
			end
			FMT_YCC16_B: begin
				r = {d[19:12], 2'h0}; // Pins 11..10 read as zero
				g = {d[9:2], 2'h0}; // Pins 1..0 read as zero
				b = '0;
			end
			FMT_YCC20: begin
				r = d[19:10];
				g = d[9:0];
				b = '0;
			end
			default: begin
				// Unknown code builds a blank pixel
				r = '0;
				g = '0;
				b = '0;
			end
		endcase
		return {r, g, b};
	endfunction : cpx_merge

	// ==========================================================
	// Per-port lanes, identical by construction
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		// ------------------------------------------------------
		// Pixel clock domain reset release
		logic prst_s1; // First stage, read only by the second
		logic prst_n; // Reset for the pixel clock logic
		// Assert at once, release on pixel clock
		always_ff @(posedge pix_clk[p] or negedge nrst) begin
			if (!nrst) begin
				prst_s1 <= 1'b0;
				prst_n <= 1'b0;
			end else begin
				prst_s1 <= 1'b1;
				prst_n <= prst_s1;
			end
		end

		// ------------------------------------------------------
		// Format select crossing into the pixel clock domain
		logic [FMT_W-1:0] fmt_s1, fmt_s2, fmt_s3; // Three stage sync
		logic [FMT_W-1:0] fmt_reg; // Format in force
		logic fmt_chg; // New format settles this cycle
		// Multi-bit code is only taken once two stages agree, so a skewed change waits
		assign fmt_chg = (fmt_s2 == fmt_s3) && (fmt_s3 != fmt_reg);
		// Format sync and hold
		always_ff @(posedge pix_clk[p] or negedge prst_n) begin
			if (!prst_n) begin
				fmt_s1 <= FMT_RESET;
				fmt_s2 <= FMT_RESET;
				fmt_s3 <= FMT_RESET;
				fmt_reg <= FMT_RESET;
			end else begin
				fmt_s1 <= fmt_sel[p];
				fmt_s2 <= fmt_s1;
				fmt_s3 <= fmt_s2;
				if (fmt_s2 == fmt_s3) begin
					fmt_reg <= fmt_s3;
				end
			end
		end

		// ------------------------------------------------------
		// Bus cycle counting and pixel assembly
		logic [CNT_W-1:0] cnt_reg; // Bus cycle within pixel
		logic [CNT_W-1:0] cnt_next;
		logic [PIXC_W-1:0] acc_reg; // Partial pixel
		logic [PIXC_W-1:0] acc_next;
		logic beat; // A data cycle that counts
		logic take; // Final cycle; pixel complete
		logic send_ready; // Crossing can accept a word
		// Line start and format switch are framing, not data
		assign beat = sensor_valid[p] && !sensor_line_start[p] && !fmt_chg;
		assign take = beat && (cnt_reg == cpx_last(fmt_reg));
		assign acc_next = cpx_merge(fmt_reg, cnt_reg, sensor_data_pin[p], acc_reg);
		// Next counter value
		always_comb begin
			cnt_next = cnt_reg;
			if (sensor_line_start[p] || fmt_chg) begin
				cnt_next = CNT_RESET; // Realign at each line
			end else if (beat) begin
				cnt_next = (cnt_reg == cpx_last(fmt_reg)) ? CNT_RESET : cnt_reg + 1'b1;
			end
		end
		// Counter register
		always_ff @(posedge pix_clk[p] or negedge prst_n) begin
			if (!prst_n) begin
				cnt_reg <= CNT_RESET;
			end else begin
				cnt_reg <= cnt_next;
			end
		end
		// Partial pixel register
		always_ff @(posedge pix_clk[p] or negedge prst_n) begin
			if (!prst_n) begin
				acc_reg <= '0;
			end else if (beat) begin
				acc_reg <= acc_next;
			end
		end

		// ------------------------------------------------------
		// Overrun: a finished pixel found the crossing busy.
		// The system clock is far slower than the pixel clock, so sustained
		// single-cycle formats will overrun; the flag tells software so.
		logic ovr_pix_reg; // Sticky, pixel domain
		logic ovr_s1, ovr_s2, ovr_s3; // Three stage sync to system clock
		logic ovr_reg; // Settled flag
		// Sticky until reset
		always_ff @(posedge pix_clk[p] or negedge prst_n) begin
			if (!prst_n) begin
				ovr_pix_reg <= 1'b0;
			end else if (take && !send_ready) begin
				ovr_pix_reg <= 1'b1;
			end
		end
		// Flag crossing
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				ovr_s1 <= 1'b0;
				ovr_s2 <= 1'b0;
				ovr_s3 <= 1'b0;
				ovr_reg <= 1'b0;
			end else begin
				ovr_s1 <= ovr_pix_reg;
				ovr_s2 <= ovr_s1;
				ovr_s3 <= ovr_s2;
				if (ovr_s2 == ovr_s3) begin
					ovr_reg <= ovr_s3;
				end
			end
		end
		assign overrun[p] = ovr_reg;

		// ------------------------------------------------------
		// Crossing and output buffer
		logic xv; // Word waiting on system clock
		logic [WORD_W-1:0] xd;
		logic xr; // Buffer has room
		logic [WORD_W-1:0] od; // Buffered word
		// Crossing stalls while the buffer is full; the lane does not stall, so a pixel finished then is dropped and flagged as overrun
		cpx_word_sync #(.W(WORD_W)) u_sync (
			.src_clk(pix_clk[p]),
			.src_rst_n(prst_n),
			.src_valid(take),
			.src_data({fmt_reg, acc_next}),
			.src_ready(send_ready),
			.clk(clk),
			.nrst(nrst),
			.dst_valid(xv),
			.dst_data(xd),
			.dst_ready(xr)
		);
		// Two entries let a consumer stall without losing a word
		cpx_pix_buffer #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
			.clk(clk),
			.nrst(nrst),
			.in_valid(xv),
			.in_data(xd),
			.in_ready(xr),
			.out_valid(pix_valid[p]),
			.out_data(od),
			.out_ready(pix_ready[p])
		);
		// Split buffered word
		assign pix_fmt[p] = od[WORD_W-1:PIXC_W];
		assign pix_c0[p] = od[3*COMP_W-1:2*COMP_W];
		assign pix_c1[p] = od[2*COMP_W-1:COMP_W];
		assign pix_c2[p] = od[COMP_W-1:0];
	end : g_port
endmodule : cpx_unpacker

// ==== inc/cpx_pkg.sv ====
// Constants and codes shared by the camera pixel unpacker
// Notes on behaviour
// - Selectable formats set pin use and cycles
// - Two camera ports share identical pin mapping
// - RGB565 two cycles: green/blue, then red/green
// - RGB565 three cycles: one component per cycle
// - RGB666 three cycles: six bits on 19..14
// - RGB888 three cycles: full byte on 19..12
// - YCbCr eight bit: one sample per cycle
// - RGB565 sixteen bit: whole pixel per cycle
// - YCbCr sixteen bit: luma high, chroma 11..4
// - YCbCr sixteen bit: chroma 9..2, left aligned
// - YCbCr twenty bit: ten bit luma, chroma
package cpx_pkg;
	// ==========================================================
	// Widths
	localparam int CPX_NUM_PORTS = 2; // Two camera ports
	localparam int DATA_W = 20; // Sensor data pins
	localparam int COMP_W = 10; // One output component slot
	localparam int FMT_W = 4; // Format select code
	localparam int CNT_W = 2; // Bus cycle counter
	localparam int PIXC_W = 3 * COMP_W; // Three component slots
	localparam int WORD_W = FMT_W + PIXC_W; // Format tag plus pixel
	localparam int BUF_DEPTH = 2; // Entries in output buffer
	// ==========================================================
	// Format codes
	localparam logic [FMT_W-1:0] FMT_RGB565_2C = 4'h0; // 8 bit, 2 cycles
	localparam logic [FMT_W-1:0] FMT_RGB565_3C = 4'h1; // 8 bit, 3 cycles
	localparam logic [FMT_W-1:0] FMT_RGB666_3C = 4'h2; // 8 bit, 3 cycles
	localparam logic [FMT_W-1:0] FMT_RGB888_3C = 4'h3; // 8 bit, 3 cycles
	localparam logic [FMT_W-1:0] FMT_YCC8_2C = 4'h4; // 8 bit, 2 cycles
	localparam logic [FMT_W-1:0] FMT_RGB565_16 = 4'h5; // 16 bit, 1 cycle
	localparam logic [FMT_W-1:0] FMT_YCC16_A = 4'h6; // 16 bit, chroma 11..4
	localparam logic [FMT_W-1:0] FMT_YCC16_B = 4'h7; // 16 bit, chroma 9..2
	localparam logic [FMT_W-1:0] FMT_YCC20 = 4'h8; // 20 bit, 1 cycle
	// ==========================================================
	// Reset values
	localparam logic [FMT_W-1:0] FMT_RESET = FMT_YCC8_2C; // Format before first sync
	localparam logic [CNT_W-1:0] CNT_RESET = 2'h0; // Cycle counter
	localparam logic [CNT_W-1:0] LAST_1C = 2'h0; // Final cycle index, 1 cycle
	localparam logic [CNT_W-1:0] LAST_2C = 2'h1; // Final cycle index, 2 cycles
	localparam logic [CNT_W-1:0] LAST_3C = 2'h2; // Final cycle index, 3 cycles
endpackage : cpx_pkg

// ==== rtl/cpx_word_sync.sv ====
// Toggle handshake carrying one word from the pixel clock to the system clock
module cpx_word_sync import cpx_pkg::*; #(
	parameter int W = WORD_W
) (
	input wire logic src_clk,
	input wire logic src_rst_n,
	input wire logic src_valid,
	input wire logic [W-1:0] src_data,
	output logic src_ready,
	input wire logic clk,
	input wire logic nrst,
	output logic dst_valid,
	output logic [W-1:0] dst_data,
	input wire logic dst_ready
);
	// ==========================================================
	// Source side
	logic req_tgl_reg; // Flips once per word sent
	logic [W-1:0] data_reg; // Held stable until acknowledged
	logic ack_s1, ack_s2, ack_s3, ack_seen_reg; // Ack toggle crossing back
	logic ack_tgl_reg; // Flips once per word taken, destination side
	assign src_ready = (req_tgl_reg == ack_seen_reg);
	// Word capture and request toggle
	always_ff @(posedge src_clk or negedge src_rst_n) begin
		if (!src_rst_n) begin
			req_tgl_reg <= 1'b0;
			data_reg <= '0;
		end else if (src_valid && src_ready) begin
			req_tgl_reg <= ~req_tgl_reg;
			data_reg <= src_data;
		end
	end
	// Ack sync; seen only once two later stages agree
	always_ff @(posedge src_clk or negedge src_rst_n) begin
		if (!src_rst_n) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ack_s3 <= 1'b0;
			ack_seen_reg <= 1'b0;
		end else begin
			ack_s1 <= ack_tgl_reg;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
			if (ack_s2 == ack_s3) begin
				ack_seen_reg <= ack_s3;
			end
		end
	end
	// ==========================================================
	// Destination side
	logic req_s1, req_s2, req_s3; // Request toggle crossing
	// Data is a source flop, stable for several cycles before the request lands
	assign dst_valid = (req_s2 == req_s3) && (req_s3 != ack_tgl_reg);
	assign dst_data = data_reg;
	// Request sync and acknowledge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
			ack_tgl_reg <= 1'b0;
		end else begin
			req_s1 <= req_tgl_reg;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			if (dst_valid && dst_ready) begin
				ack_tgl_reg <= ~ack_tgl_reg;
			end
		end
	end
endmodule : cpx_word_sync

// ==== rtl/cpx_pix_buffer.sv ====
// Small valid/ready buffer in front of the pixel consumer
module cpx_pix_buffer import cpx_pkg::*; #(
	parameter int W = WORD_W,
	parameter int DEPTH = BUF_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // Pointer width
	localparam int CW = $clog2(DEPTH + 1); // Occupancy width
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1); // Wrap point
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH); // Full mark
	logic [W-1:0] mem [DEPTH]; // Storage flops
	logic [AW-1:0] wr_ptr_reg, rd_ptr_reg; // Ring pointers
	logic [CW-1:0] count_reg; // Occupancy
	logic push, pop; // Handshakes this cycle
	assign in_ready = (count_reg != CNT_FULL);
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Storage write; no reset needed, guarded by occupancy
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end
	// Pointers and occupancy
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule : cpx_pix_buffer

// ==== testbench/cpx_unpacker_properties.sv ====
// Concurrent checks on the output side of the camera pixel unpacker
module cpx_unpacker_properties import cpx_pkg::*; #(
	parameter int NUM_PORTS = CPX_NUM_PORTS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [NUM_PORTS-1:0] pix_valid,
	input wire logic [NUM_PORTS-1:0] pix_ready,
	input wire logic [NUM_PORTS-1:0][FMT_W-1:0] pix_fmt,
	input wire logic [NUM_PORTS-1:0][COMP_W-1:0] pix_c0,
	input wire logic [NUM_PORTS-1:0][COMP_W-1:0] pix_c1,
	input wire logic [NUM_PORTS-1:0][COMP_W-1:0] pix_c2
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Clocking
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// True when a slot holds nothing above bit n-1
	function automatic logic fits(input logic [COMP_W-1:0] x, input int n);
		return (x >> n) == '0;
	endfunction : fits
	// ==========================================================
	// Buffer hold: a stalled word must not change under the consumer
	AST_HOLD_P0: assert property (pix_valid[0] && !pix_ready[0] |=> pix_valid[0] &&
		$stable(pix_c0[0]) && $stable(pix_c1[0]) && $stable(pix_c2[0]) && $stable(pix_fmt[0]))
		else $error("port 0 word moved while stalled");
	AST_HOLD_P1: assert property (pix_valid[1] && !pix_ready[1] |=> pix_valid[1] &&
		$stable(pix_c0[1]) && $stable(pix_c1[1]) && $stable(pix_c2[1]) && $stable(pix_fmt[1]))
		else $error("port 1 word moved while stalled");
	// No pixel on port 0 can exist straight after reset, no cycles were taken yet
	AST_RST_EMPTY: assert property ($rose(nrst) |-> !pix_valid[0] ##1 !pix_valid[0])
		else $error("pixel right after reset");
	// ==========================================================
	// Component widths per format; a stray pin shows as a high bit
	AST_RGB565_2C: assert property (pix_valid[0] && pix_fmt[0] == FMT_RGB565_2C |->
		fits(pix_c0[0], 5) && fits(pix_c1[0], 6) && fits(pix_c2[0], 5)) else $error("rgb565 width");
	AST_RGB666: assert property (pix_valid[0] && pix_fmt[0] == FMT_RGB666_3C |->
		fits(pix_c0[0], 6) && fits(pix_c1[0], 6) && fits(pix_c2[0], 6)) else $error("rgb666 width");
	AST_RGB888: assert property (pix_valid[0] && pix_fmt[0] == FMT_RGB888_3C |->
		fits(pix_c0[0], 8) && fits(pix_c1[0], 8) && fits(pix_c2[0], 8)) else $error("rgb888 width");
	AST_YCC8: assert property (pix_valid[0] && pix_fmt[0] == FMT_YCC8_2C |->
		fits(pix_c0[0], 8) && fits(pix_c1[0], 8) && pix_c2[0] == 10'h0) else $error("ycc8 width");
	AST_YCC16_B: assert property (pix_valid[0] && pix_fmt[0] == FMT_YCC16_B |->
		pix_c0[0][1:0] == 2'h0 && pix_c1[0][1:0] == 2'h0 && pix_c2[0] == 10'h0) else $error("ycc16 align");
	AST_YCC20: assert property (pix_valid[0] && pix_fmt[0] == FMT_YCC20 |->
		pix_c2[0] == 10'h0) else $error("ycc20 third slot");
endmodule : cpx_unpacker_properties

bind cpx_unpacker cpx_unpacker_properties #(.NUM_PORTS(NUM_PORTS)) u_props (
	.clk(clk),
	.nrst(nrst),
	.pix_valid(pix_valid),
	.pix_ready(pix_ready),
	.pix_fmt(pix_fmt),
	.pix_c0(pix_c0),
	.pix_c1(pix_c1),
	.pix_c2(pix_c2)
);

// ==== testbench/cpx_sensor_model.sv ====
// Behavioural parallel camera sensor driving one port
module cpx_sensor_model import cpx_pkg::*; (
	output logic pclk,
	output logic [DATA_W-1:0] data,
	output logic valid,
	output logic line_start
);
	timeunit 1ns;
	timeprecision 100ps;
	// Clock stands still low between frames
	initial begin
		pclk = 1'b0;
		data = '0;
		valid = 1'b0;
		line_start = 1'b0;
	end
	// One 6 ns pixel clock period; pins change only while the clock is low
	task automatic tick(input logic [DATA_W-1:0] d, input logic v, input logic ls);
		data = d;
		valid = v;
		line_start = ls;
		#3 pclk = 1'b1;
		#3 pclk = 1'b0;
	endtask : tick
	// Released pins flip to the inverse of their previous value on every idle cycle
	task automatic idle(input int n);
		repeat (n) tick(~data, 1'b0, 1'b0);
	endtask : idle
	// Lead-in, line start, n data cycles, then a gap
	task automatic frame(input logic [DATA_W-1:0] w[3], input int n, input int gap);
		idle(10);
		tick(~data, 1'b0, 1'b1);
		for (int k = 0; k < n; k++) tick(w[k], 1'b1, 1'b0);
		idle(gap);
	endtask : frame
endmodule : cpx_sensor_model

// ==== testbench/tb_camera_sensor_pixel_unpacker.sv ====
// Self-checking bench for the camera pixel unpacker
module tb_camera_sensor_pixel_unpacker import cpx_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Signals
	logic clk, nrst; // System clock and reset
	wire [1:0] pix_clk; // Driven by the sensor models
	wire [1:0][DATA_W-1:0] sensor_data_pin;
	wire [1:0] sensor_valid, sensor_line_start;
	logic [1:0][FMT_W-1:0] fmt_sel;
	logic [1:0] pix_valid, pix_ready, overrun;
	logic [1:0][FMT_W-1:0] pix_fmt;
	logic [1:0][COMP_W-1:0] pix_c0, pix_c1, pix_c2;
	int fail_count, check_count, cycles;
	// ==========================================================
	// Instances
	cpx_unpacker #(.NUM_PORTS(2)) u_dut (.clk(clk), .nrst(nrst), .pix_clk(pix_clk),
		.sensor_data_pin(sensor_data_pin), .sensor_valid(sensor_valid), .sensor_line_start(sensor_line_start),
		.fmt_sel(fmt_sel), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_fmt(pix_fmt),
		.pix_c0(pix_c0), .pix_c1(pix_c1), .pix_c2(pix_c2), .overrun(overrun));
	cpx_sensor_model m0 (.pclk(pix_clk[0]), .data(sensor_data_pin[0]), .valid(sensor_valid[0]),
		.line_start(sensor_line_start[0]));
	cpx_sensor_model m1 (.pclk(pix_clk[1]), .data(sensor_data_pin[1]), .valid(sensor_valid[1]),
		.line_start(sensor_line_start[1]));
	// 25 MHz system clock
	always #20 clk = ~clk;
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			final_report();
		end
	end
	// ==========================================================
	// Helpers
	task automatic chk(input string name, input logic [33:0] got, input logic [33:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// Bus cycles per pixel
	function automatic int ncyc(input logic [FMT_W-1:0] f);
		case (f)
			FMT_RGB565_2C, FMT_YCC8_2C: return 2;
			FMT_RGB565_3C, FMT_RGB666_3C, FMT_RGB888_3C: return 3;
			default: return 1;
		endcase
	endfunction : ncyc
	// Expected {format, c0, c1, c2} from the pin mapping of each format
	function automatic logic [33:0] expect_word(input logic [FMT_W-1:0] f, input logic [DATA_W-1:0] a, b, c);
		case (f)
			FMT_RGB565_2C: return {f, 5'h0, b[19:15], 4'h0, b[14:12], a[19:17], 5'h0, a[16:12]};
			FMT_RGB565_3C: return {f, 5'h0, a[19:15], 4'h0, b[19:14], 5'h0, c[19:15]};
			FMT_RGB666_3C: return {f, 4'h0, a[19:14], 4'h0, b[19:14], 4'h0, c[19:14]};
			FMT_RGB888_3C: return {f, 2'h0, a[19:12], 2'h0, b[19:12], 2'h0, c[19:12]};
			FMT_YCC8_2C: return {f, 2'h0, b[19:12], 2'h0, a[19:12], 10'h0};
			FMT_RGB565_16: return {f, 5'h0, a[19:15], 4'h0, a[14:9], 5'h0, a[8:4]};
			FMT_YCC16_A: return {f, 2'h0, a[19:12], 2'h0, a[11:4], 10'h0};
			FMT_YCC16_B: return {f, a[19:12], 2'h0, a[9:2], 2'h0, 10'h0};
			FMT_YCC20: return {f, a[19:10], a[9:0], 10'h0};
			default: return {f, 30'h0}; // Unknown code gives a blank pixel
		endcase
	endfunction : expect_word
	// Both sensors send the same frame at once
	task automatic send(input logic [FMT_W-1:0] f, input logic [DATA_W-1:0] w[3], input int n, input int gap);
		fmt_sel = {f, f};
		fork
			m0.frame(w, n, gap);
			m1.frame(w, n, gap);
		join
	endtask : send
	// Wait for a word on port p, compare it, then accept it for one cycle
	task automatic take(input int p, input logic [33:0] exp);
		int n;
		n = 0;
		@(negedge clk);
		while (pix_valid[p] !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk("word", {pix_fmt[p], pix_c0[p], pix_c1[p], pix_c2[p]}, exp);
		pix_ready[p] = 1'b1;
		@(negedge clk);
		pix_ready[p] = 1'b0;
	endtask : take
	// ==========================================================
	// Scenarios
	// Every format with all pins busy; unused pins must not leak in
	task automatic t_formats();
		logic [DATA_W-1:0] w[3];
		logic [33:0] e;
		for (int f = 0; f < 10; f++) begin
			for (int k = 0; k < 3; k++) w[k] = 20'h9c6b5 + 20'(20'h3a5e7 * (k + 1)) + 20'(f);
			e = expect_word(FMT_W'(f), w[0], w[1], w[2]);
			send(FMT_W'(f), w, ncyc(FMT_W'(f)), 40);
			take(0, e);
			take(1, e);
		end
	endtask : t_formats
	// A partial pixel cut off by the next line start is thrown away
	task automatic t_abort();
		logic [DATA_W-1:0] w[3];
		w = '{20'h12345, 20'habcde, 20'h5f0a3};
		send(FMT_RGB888_3C, w, 1, 4);
		send(FMT_RGB888_3C, w, 3, 40);
		take(0, expect_word(FMT_RGB888_3C, w[0], w[1], w[2]));
		repeat (20) @(negedge clk);
		chk("valid", 34'(pix_valid), 34'h2);
		take(1, expect_word(FMT_RGB888_3C, w[0], w[1], w[2]));
	endtask : t_abort
	// Consumer stalls: two words buffered, one held in the crossing, rest dropped
	task automatic t_stall();
		logic [DATA_W-1:0] w[3];
		logic [33:0] e[3];
		for (int k = 0; k < 5; k++) begin
			w = '{20'(20'h1f3c7 * k + 20'h00a55), 20'h0, 20'h0};
			if (k < 3) e[k] = expect_word(FMT_YCC20, w[0], w[1], w[2]);
			send(FMT_YCC20, w, 1, 40);
		end
		chk("overrun", 34'(overrun), 34'h3);
		for (int k = 0; k < 3; k++) begin
			take(0, e[k]);
			take(1, e[k]);
		end
		repeat (20) @(negedge clk);
		chk("valid", 34'(pix_valid), 34'h0);
	endtask : t_stall
	// ==========================================================
	// Verdict
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	// Main sequence
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		pix_ready = 2'h0;
		fmt_sel = {FMT_RESET, FMT_RESET};
		fail_count = 0;
		check_count = 0;
		cycles = 0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		t_formats();
		t_abort();
		t_stall();
		final_report();
	end
endmodule : tb_camera_sensor_pixel_unpacker
